/* File: design/debin_consts.vh */
// constants shared by the bin-to-value decoding block
// assumes inclusion by bare name from the debinarizer and decoder files
`ifndef DEBIN_CONSTS_VH
`define DEBIN_CONSTS_VH
// command opcodes, also used as result tags
`define OP_CBP      4'h0
`define OP_DQP      4'h1
`define OP_IPL      4'h2
`define OP_IPC      4'h3
`define OP_REF      4'h4
`define OP_MVD      4'h5
`define OP_COEF     4'h6
`define OP_SKIP     4'h7
`define OP_EOS      4'h8
`define TAG_MVD_V   4'h9
`define TAG_CF_END  4'hA
// bin request modes
`define MODE_CTX    2'h0
`define MODE_BYP    2'h1
`define MODE_EOS    2'h2
// code shapes
`define CBP_LUMA_BINS 8'h04
`define CBP_CHR_MAX   8'h02
`define CBP_CHR_MUL   8'h10
`define IPL_MAX       8'h08
`define IPC_MAX       8'h03
`define UNARY_CAP     8'hFF
`define MVD_ORDER     5'h03
`define MVD_CUTOFF    5'h09
`define CF_ORDER      5'h00
`define CF_CUTOFF     5'h0E
`define SKIP_INV      1'h1
// fixed end-of-slice model
`define EOS_STATE     6'h3F
`define EOS_LIKELY    1'h0
// result path
`define RES_DEPTH     16
`define SCAN_LEN      5'h10
`endif

/* File: design/res_fifo.v */
// flip-flop FIFO with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
`timescale 1ns/10ps
module res_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             sys_rst_i,
	// fill side
	input  wire             in_vld_i,
	output wire             in_rdy_o,
	input  wire [WIDTH-1:0] in_dat_i,
	// drain side
	output wire             out_vld_o,
	input  wire             out_rdy_i,
	output wire [WIDTH-1:0] out_dat_o
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // storage
	reg [AW-1:0]    wr_r;              // write index
	reg [AW-1:0]    rd_r;              // read index
	reg [AW:0]      cnt_r;             // fill level
	wire            push;
	wire            pop;
	assign in_rdy_o  = (cnt_r != DEPTH[AW:0]);
	assign out_vld_o = (cnt_r != {(AW+1){1'b0}});
	assign out_dat_o = mem_r[rd_r];
	assign push      = in_vld_i & in_rdy_o;
	assign pop       = out_vld_o & out_rdy_i;
	// data store, no reset needed
	always @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_dat_i;
		end
	end
	// pointers and level
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_r  <= {AW{1'b0}};
			rd_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) wr_r <= wr_r + 1'b1;
			if (pop) rd_r <= rd_r + 1'b1;
			if (push & ~pop) cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

/* File: design/syntax_element_debinarizer.v */
// turns bins from the arithmetic engine into syntax element values
// assumes the engine, command source and result sink share clk_i
`timescale 1ns/10ps
`include "debin_consts.vh"
// Behaviour
// - luma pattern: four fixed bins, 0..15
// - chroma capped at 2; pattern luma+16*chroma
// - quantizer change: unary count, then signed
// - luma intra indicator capped unary, max 8
// - zero picks likely mode, else selector
// - chroma intra mode capped unary, max 3
// - reference index as plain unary
// - mvd horizontal first; magnitude then sign
// - mvd magnitude unary cut 9, golomb order 3
// - mvd signs and suffix use bypass
// - sign bin 0 positive, 1 negative
// - coded flag unless pattern shows empty
// - zero coded flag ends block
// - significance except last; last-bin if significant
// - last-bin one ends scan, rest zero
// - levels reverse order, magnitude then sign
// - level unary cut 14, golomb order 0
// - skip bin inverted by xor 0x01
// - end-of-slice model state 63, likely 0
// - likely end-of-slice keeps state 63
// - end-of-slice one reinitialises all contexts
module syntax_element_debinarizer #(
	parameter RES_DEPTH = `RES_DEPTH,
	parameter RES_AW    = 4
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        sys_rst_i,
	// command from the parser
	input  wire        cmd_vld_i,
	output wire        cmd_rdy_o,
	input  wire [3:0]  cmd_op_i,
	input  wire [3:0]  cmd_mpm_i,
	input  wire        cmd_blk_coded_i,
	input  wire [4:0]  cmd_scan_len_i,
	// bin request to the arithmetic engine
	output wire        bin_req_o,
	output wire [1:0]  bin_mode_o,
	output wire [3:0]  bin_se_o,
	output wire [1:0]  bin_sub_o,
	output wire [4:0]  bin_idx_o,
	input  wire        bin_vld_i,
	input  wire        bin_val_i,
	// fixed end-of-slice model and context refresh
	output wire [5:0]  eos_state_o,
	output wire        eos_likely_o,
	output reg         ctx_reinit_o,
	// decoded values
	output wire        res_vld_o,
	input  wire        res_rdy_i,
	output wire [3:0]  res_tag_o,
	output wire [15:0] res_val_o
);
	// ****************************************
	// states and storage
	// ****************************************
	localparam S_IDLE = 5'h01; // waiting for a command
	localparam S_BIN  = 5'h02; // waiting for one bin
	localparam S_UEG  = 5'h04; // magnitude decoder busy
	localparam S_PUSH = 5'h08; // writing a result
	localparam S_SCAN = 5'h10; // walking levels backwards
	reg [4:0]  st_r;           // main state
	reg [4:0]  ret_r;          // state after a push
	reg [3:0]  op_r;           // element in progress
	reg [1:0]  ph_r;           // sub-step of the element
	reg [7:0]  cnt_r;          // bins counted
	reg [3:0]  luma_r;         // luma pattern bits
	reg [3:0]  mpm_r;          // likely intra mode
	reg [4:0]  len_r;          // scan length
	reg [15:0] sig_r;          // significance map
	reg [4:0]  pos_r;          // scan position
	reg        comp_r;         // 0 horizontal, 1 vertical
	reg [15:0] mag_r;          // magnitude awaiting sign
	reg [3:0]  tag_r;          // result tag
	reg [15:0] val_r;          // result value
	reg        ueg_go_r;       // start pulse
	reg [4:0]  ueg_ord_r;      // golomb order
	reg [4:0]  ueg_cut_r;      // unary cut-off
	reg [5:0]  eos_st_r;       // end-of-slice model state
	wire       ueg_done;
	wire [15:0] ueg_val;
	wire       ueg_req;
	wire       ueg_byp;
	wire [4:0] ueg_idx;
	wire       fifo_rdy;
	wire       in_bin;
	wire       got;
	// ****************************************
	// value mapping functions
	// ****************************************
	// signed value from magnitude and sign bin
	function [15:0] apply_sign;
		input [15:0] mag;
		input        neg;
		begin
			apply_sign = neg ? (16'h0000 - mag) : mag;
		end
	endfunction
	// code number to signed quantizer change
	function [15:0] dqp_map;
		input [7:0] k;
		begin
			if (k[0]) dqp_map = {8'h00, 1'b0, k[7:1]} + 16'h0001;
			else dqp_map = 16'h0000 - {9'h000, k[7:1]};
		end
	endfunction
	// ****************************************
	// capped unary step
	// ****************************************
	reg [7:0] tu_lim;         // cap for current element
	wire [7:0] tu_n;          // count including this bin
	wire       tu_end;        // code complete
	wire [7:0] tu_v;          // decoded count
	// cap chosen by element
	always @* begin
		case (op_r)
			`OP_CBP: tu_lim = `CBP_CHR_MAX;
			`OP_IPL: tu_lim = `IPL_MAX;
			`OP_IPC: tu_lim = `IPC_MAX;
			default: tu_lim = `UNARY_CAP;
		endcase
	end
	assign tu_n   = cnt_r + 8'h01;
	assign tu_end = ~bin_val_i | (tu_n == tu_lim);
	assign tu_v   = bin_val_i ? tu_n : cnt_r;
	// intra mode from indicator and likely mode
	wire [3:0] ind_sel = tu_v[3:0] - 4'h1;
	wire [3:0] ipl_mode = (tu_v == 8'h00) ? mpm_r :
		((ind_sel < mpm_r) ? ind_sel : ind_sel + 4'h1);
	// ****************************************
	// engine request multiplexing
	// ****************************************
	assign in_bin    = (st_r == S_BIN);
	assign got       = in_bin & bin_vld_i;
	assign bin_req_o = in_bin | ((st_r == S_UEG) & ueg_req);
	assign bin_mode_o = (st_r == S_UEG) ? (ueg_byp ? `MODE_BYP : `MODE_CTX) :
		(op_r == `OP_EOS) ? `MODE_EOS :
		((ph_r == 2'h3) ? `MODE_BYP : `MODE_CTX);
	assign bin_se_o  = op_r;
	assign bin_sub_o = ph_r;
	assign bin_idx_o = (st_r == S_UEG) ? ueg_idx :
		((op_r == `OP_COEF) ? pos_r : cnt_r[4:0]);
	assign cmd_rdy_o = (st_r == S_IDLE);
	assign eos_state_o  = eos_st_r;
	assign eos_likely_o = `EOS_LIKELY;
	// ****************************************
	// magnitude decoder and result buffer
	// ****************************************
	// the decoder only sees answers while it owns the request
	ueg_decoder u_ueg (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (ueg_go_r),
		.order_i   (ueg_ord_r),
		.cutoff_i  (ueg_cut_r),
		.done_o    (ueg_done),
		.value_o   (ueg_val),
		.req_o     (ueg_req),
		.bypass_o  (ueg_byp),
		.idx_o     (ueg_idx),
		.bin_vld_i (bin_vld_i & (st_r == S_UEG)),
		.bin_val_i (bin_val_i)
	);
	// results wait here so a slow sink stalls only the push state
	res_fifo #(
		.WIDTH (20),
		.DEPTH (RES_DEPTH),
		.AW    (RES_AW)
	) u_fifo (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.in_vld_i  (st_r == S_PUSH),
		.in_rdy_o  (fifo_rdy),
		.in_dat_i  ({tag_r, val_r}),
		.out_vld_o (res_vld_o),
		.out_rdy_i (res_rdy_i),
		.out_dat_o ({res_tag_o, res_val_o})
	);
	// ****************************************
	// element sequencer
	// ****************************************
	// one process walks every element's bins, except magnitude bins, which the decoder walks
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// every register starts from a constant
			// sequencer position
			st_r <= S_IDLE;
			ret_r <= S_IDLE;
			op_r <= 4'h0;
			ph_r <= 2'h0;
			// element context
			cnt_r <= 8'h00;
			luma_r <= 4'h0;
			mpm_r <= 4'h0;
			len_r <= `SCAN_LEN;
			// scan bookkeeping
			sig_r <= 16'h0000;
			pos_r <= 5'h00;
			comp_r <= 1'b0;
			mag_r <= 16'h0000;
			// result and decoder launch
			tag_r <= 4'h0;
			val_r <= 16'h0000;
			ueg_go_r <= 1'b0;
			ueg_ord_r <= 5'h00;
			ueg_cut_r <= 5'h00;
			// fixed end-of-slice model
			eos_st_r <= `EOS_STATE;
			ctx_reinit_o <= 1'b0;
		end else begin
			ueg_go_r <= 1'b0;
			ctx_reinit_o <= 1'b0;
			case (st_r)
			// take a command
			S_IDLE: if (cmd_vld_i) begin
				// latch the command and clear the per-element state
				op_r <= cmd_op_i;
				ph_r <= 2'h0;
				cnt_r <= 8'h00;
				luma_r <= 4'h0;
				mpm_r <= cmd_mpm_i;
				len_r <= cmd_scan_len_i;
				sig_r <= 16'h0000;
				pos_r <= 5'h00;
				comp_r <= 1'b0;
				tag_r <= cmd_op_i;
				case (cmd_op_i)
				`OP_MVD: begin
					ueg_go_r <= 1'b1; ueg_ord_r <= `MVD_ORDER;
					ueg_cut_r <= `MVD_CUTOFF; st_r <= S_UEG;
				end
				`OP_COEF: if (!cmd_blk_coded_i) begin
					tag_r <= `TAG_CF_END; val_r <= 16'h0000;
					ret_r <= S_IDLE; st_r <= S_PUSH;
				end else st_r <= S_BIN;
				`OP_CBP, `OP_DQP, `OP_IPL, `OP_IPC, `OP_REF, `OP_SKIP, `OP_EOS:
					st_r <= S_BIN;
				default: st_r <= S_IDLE;
				endcase
			end
			// one bin answered
			S_BIN: if (bin_vld_i) begin
				ret_r <= S_IDLE;
				case (op_r)
				`OP_CBP: if (ph_r == 2'h0) begin
					luma_r[cnt_r[1:0]] <= bin_val_i;
					cnt_r <= tu_n;
					if (tu_n == `CBP_LUMA_BINS) begin
						ph_r <= 2'h1; cnt_r <= 8'h00;
					end
				end else if (tu_end) begin
					val_r <= {12'h000, luma_r} + {8'h00, tu_v} * `CBP_CHR_MUL;
					st_r <= S_PUSH;
				end else cnt_r <= tu_n;
				`OP_DQP: if (!bin_val_i || tu_n == `UNARY_CAP) begin
					val_r <= dqp_map(tu_v); st_r <= S_PUSH;
				end else cnt_r <= tu_n;
				`OP_IPL: if (tu_end) begin
					val_r <= {11'h000, (tu_v == 8'h00), ipl_mode};
					st_r <= S_PUSH;
				end else cnt_r <= tu_n;
				`OP_IPC, `OP_REF: if (tu_end) begin
					val_r <= {8'h00, tu_v}; st_r <= S_PUSH;
				end else cnt_r <= tu_n;
				`OP_MVD: begin
					val_r <= apply_sign(mag_r, bin_val_i); st_r <= S_PUSH;
					if (!comp_r) ret_r <= S_UEG;
				end
				`OP_SKIP: begin
					val_r <= {15'h0000, bin_val_i ^ `SKIP_INV}; st_r <= S_PUSH;
				end
				`OP_EOS: begin
					val_r <= {15'h0000, bin_val_i}; st_r <= S_PUSH;
					if (bin_val_i) ctx_reinit_o <= 1'b1;
					eos_st_r <= `EOS_STATE;
				end
				`OP_COEF: case (ph_r)
					2'h0: if (!bin_val_i) begin
						tag_r <= `TAG_CF_END; val_r <= 16'h0000;
						st_r <= S_PUSH;
					end else if (len_r <= 5'h01) begin
						sig_r[0] <= 1'b1; st_r <= S_SCAN;
					end else ph_r <= 2'h1;
					2'h1: if (bin_val_i) begin
						sig_r[pos_r[3:0]] <= 1'b1; ph_r <= 2'h2;
					end else if (pos_r + 5'h01 == len_r - 5'h01) begin
						pos_r <= pos_r + 5'h01;
						sig_r[pos_r[3:0] + 4'h1] <= 1'b1; st_r <= S_SCAN;
					end else pos_r <= pos_r + 5'h01;
					2'h2: if (bin_val_i) st_r <= S_SCAN;
					else if (pos_r + 5'h01 == len_r - 5'h01) begin
						pos_r <= pos_r + 5'h01;
						sig_r[pos_r[3:0] + 4'h1] <= 1'b1; st_r <= S_SCAN;
					end else begin
						pos_r <= pos_r + 5'h01; ph_r <= 2'h1;
					end
					default: begin
						val_r <= apply_sign(mag_r, bin_val_i);
						ret_r <= S_SCAN; st_r <= S_PUSH;
					end
				endcase
				default: st_r <= S_IDLE;
				endcase
			end
			// magnitude finished
			S_UEG: if (ueg_done) begin
				// levels always carry a sign bin, a zero vector part none
				if (op_r == `OP_COEF) begin
					mag_r <= ueg_val + 16'h0001; ph_r <= 2'h3; st_r <= S_BIN;
				end else if (ueg_val == 16'h0000) begin
					val_r <= 16'h0000; st_r <= S_PUSH;
					ret_r <= comp_r ? S_IDLE : S_UEG;
				end else begin
					mag_r <= ueg_val; ph_r <= 2'h3; st_r <= S_BIN;
				end
			end
			// walk significant positions from the end
			S_SCAN: if (sig_r[pos_r[3:0]]) begin
				// clear the sub-step so a level prefix never looks like a sign
				ph_r <= 2'h0;
				sig_r[pos_r[3:0]] <= 1'b0;
				ueg_go_r <= 1'b1;
				ueg_ord_r <= `CF_ORDER; ueg_cut_r <= `CF_CUTOFF;
				st_r <= S_UEG;
			end else if (pos_r == 5'h00) begin
				tag_r <= `TAG_CF_END; val_r <= 16'h0000;
				ret_r <= S_IDLE; st_r <= S_PUSH;
			end else pos_r <= pos_r - 5'h01;
			// hand the value to the buffer, stall while full
			S_PUSH: if (fifo_rdy) begin
				st_r <= ret_r;
				if (ret_r == S_UEG) begin
					comp_r <= 1'b1; tag_r <= `TAG_MVD_V; ph_r <= 2'h0;
					ueg_go_r <= 1'b1;
				end
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: design/ueg_decoder.v */
// unary prefix plus exp-golomb suffix magnitude decoder
// assumes the engine answers each held request with bin_vld_i
`timescale 1ns/10ps
`include "debin_consts.vh"
module ueg_decoder (
	// clock and reset
	input  wire        clk_i,
	input  wire        sys_rst_i,
	// control
	input  wire        start_i,
	input  wire [4:0]  order_i,
	input  wire [4:0]  cutoff_i,
	output reg         done_o,
	output reg  [15:0] value_o,
	// bin requests
	output wire        req_o,
	output wire        bypass_o,
	output wire [4:0]  idx_o,
	input  wire        bin_vld_i,
	input  wire        bin_val_i
);
	localparam ST_IDLE = 4'h1; // waiting
	localparam ST_PRE  = 4'h2; // context prefix
	localparam ST_ESC  = 4'h4; // suffix ones
	localparam ST_SUF  = 4'h8; // suffix bits
	reg [3:0]  st_r;           // state
	reg [4:0]  cnt_r;          // prefix bins seen
	reg [4:0]  k_r;            // current order
	reg [4:0]  cut_r;          // cut-off
	reg [15:0] sym_r;          // suffix sum
	assign req_o    = (st_r != ST_IDLE);
	assign bypass_o = (st_r == ST_ESC) | (st_r == ST_SUF);
	assign idx_o    = cnt_r;
	// prefix then bypass suffix
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= ST_IDLE; cnt_r <= 5'h00; k_r <= 5'h00;
			cut_r <= 5'h00; sym_r <= 16'h0000;
			done_o <= 1'b0; value_o <= 16'h0000;
		end else begin
			done_o <= 1'b0;
			case (st_r)
			ST_IDLE: if (start_i) begin
				st_r <= ST_PRE; cnt_r <= 5'h00; k_r <= order_i;
				cut_r <= cutoff_i; sym_r <= 16'h0000;
			end
			ST_PRE: if (bin_vld_i) begin
				if (!bin_val_i) begin
					done_o <= 1'b1; value_o <= {11'h000, cnt_r}; st_r <= ST_IDLE;
				end else begin
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r + 5'h01 == cut_r) st_r <= ST_ESC;
				end
			end
			ST_ESC: if (bin_vld_i) begin
				if (bin_val_i) begin
					sym_r <= sym_r + (16'h0001 << k_r); k_r <= k_r + 5'h01;
				end else if (k_r == 5'h00) begin
					done_o <= 1'b1; value_o <= sym_r + {11'h000, cut_r};
					st_r <= ST_IDLE;
				end else st_r <= ST_SUF;
			end
			ST_SUF: if (bin_vld_i) begin
				k_r <= k_r - 5'h01;
				if (k_r == 5'h01) begin
					done_o <= 1'b1; st_r <= ST_IDLE;
					value_o <= sym_r + {11'h000, cut_r} + {15'h0000, bin_val_i};
				end else sym_r <= sym_r + ({15'h0000, bin_val_i} << (k_r - 5'h01));
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end
endmodule

/* File: dv/bin_engine_model.sv */
// behavioural arithmetic engine answering bin requests from a queue
// assumes the bench pushes bins in decode order before each command
`timescale 1ns/10ps
module bin_engine_model (
	// clock and reset
	input  wire       clk_i,
	input  wire       sys_rst_i,
	// bin request from the block
	input  wire       bin_req_i,
	input  wire [1:0] bin_mode_i,
	// answer
	output reg        bin_vld_o,
	output reg        bin_val_o
);
	logic q[$];       // bins still to hand out
	int   lag     = 0; // cycles to stall before answering
	int   wait_n  = 0; // stall counter
	int   byp_n   = 0; // bins served in bypass mode
	int   eos_n   = 0; // bins served from the fixed model
	int   starved = 0; // requests met with an empty queue

	// load one bin for a later request
	task push(input logic b);
		q.push_back(b);
	endtask

	// answer a held request after lag cycles, one-cycle valid
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bin_vld_o <= 1'b0;
			bin_val_o <= 1'b0;
			wait_n    <= 0;
		end else if (bin_vld_o) begin
			// answer taken: the value line no longer carries the bin
			bin_vld_o <= 1'b0;
			bin_val_o <= ~bin_val_o;
		end else if (bin_req_i === 1'b1 && wait_n < lag) begin
			wait_n <= wait_n + 1;
		end else if (bin_req_i === 1'b1) begin
			wait_n    <= 0;
			bin_vld_o <= 1'b1;
			if (bin_mode_i == 2'h1) byp_n <= byp_n + 1;
			if (bin_mode_i == 2'h2) eos_n <= eos_n + 1;
			if (q.size() == 0) begin
				starved   <= starved + 1;
				bin_val_o <= ~bin_val_o;
			end else begin
				bin_val_o <= q.pop_front();
			end
		end else begin
			// idle: keep the value line moving so nothing stale is read
			bin_val_o <= ~bin_val_o;
		end
	end
endmodule

/* File: dv/debin_checker.sv */
// concurrent checks on the ports of the bin-to-value block
// assumes one clock domain, reset active high
`timescale 1ns/10ps
module debin_checker (
	// clock and reset
	input wire        clk_i,
	input wire        sys_rst_i,
	// command side
	input wire        cmd_vld_i,
	input wire        cmd_rdy_o,
	input wire [3:0]  cmd_op_i,
	input wire [3:0]  cmd_mpm_i,
	input wire        cmd_blk_coded_i,
	input wire [4:0]  cmd_scan_len_i,
	// engine side
	input wire        bin_req_o,
	input wire [1:0]  bin_mode_o,
	input wire [3:0]  bin_se_o,
	input wire [1:0]  bin_sub_o,
	input wire [4:0]  bin_idx_o,
	input wire        bin_vld_i,
	input wire        bin_val_i,
	input wire [5:0]  eos_state_o,
	input wire        eos_likely_o,
	input wire        ctx_reinit_o,
	// result side
	input wire        res_vld_o,
	input wire        res_rdy_i,
	input wire [3:0]  res_tag_o,
	input wire [15:0] res_val_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_eos_fixed: assert property (eos_state_o == 6'h3F && eos_likely_o == 1'b0)
		else $error("end-of-slice model not fixed");
	a_eos_keep: assert property (bin_req_o && bin_se_o == 4'h8 |=> eos_state_o == 6'h3F)
		else $error("end-of-slice state moved");
	a_reinit_cause: assert property (ctx_reinit_o |->
		$past(bin_req_o) && $past(bin_vld_i) && $past(bin_mode_o) == 2'h2 && $past(bin_val_i))
		else $error("context refresh without end-of-slice one");
	a_reinit_when: assert property (bin_req_o && bin_vld_i && bin_mode_o == 2'h2
		&& bin_val_i |=> ctx_reinit_o ##1 !ctx_reinit_o)
		else $error("context refresh pulse missing");
	a_skip_ctx: assert property (bin_req_o && bin_se_o == 4'h7 |-> bin_mode_o == 2'h0)
		else $error("skip bin not context coded");
	a_eos_mode: assert property (bin_req_o && bin_se_o == 4'h8 |-> bin_mode_o == 2'h2)
		else $error("end-of-slice bin not on fixed model");
	a_sign_bypass: assert property (bin_req_o && bin_se_o == 4'h6 && bin_sub_o == 2'h3
		|-> bin_mode_o == 2'h1)
		else $error("level sign not bypass");
	a_luma_fixed: assert property (bin_req_o && bin_se_o == 4'h0 && bin_sub_o == 2'h0
		|-> bin_idx_o < 5'h04 && bin_mode_o == 2'h0)
		else $error("luma pattern bin out of range");
	a_chroma_cap: assert property (bin_req_o && bin_se_o == 4'h0 && bin_sub_o == 2'h1
		|-> bin_idx_o < 5'h02)
		else $error("chroma pattern bin beyond cap");
	a_intra_cap: assert property (bin_req_o && bin_se_o == 4'h2 |-> bin_idx_o < 5'h08)
		else $error("luma intra bin beyond cap");
	a_chroma_intra: assert property (bin_req_o && bin_se_o == 4'h3 |-> bin_idx_o < 5'h03)
		else $error("chroma intra bin beyond cap");
	a_req_hold: assert property (bin_req_o && !bin_vld_i |=> bin_req_o
		&& $stable(bin_mode_o) && $stable(bin_idx_o) && $stable(bin_se_o))
		else $error("bin request changed before answer");
endmodule

bind syntax_element_debinarizer debin_checker chk_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_vld_i(cmd_vld_i), .cmd_rdy_o(cmd_rdy_o),
	.cmd_op_i(cmd_op_i), .cmd_mpm_i(cmd_mpm_i), .cmd_blk_coded_i(cmd_blk_coded_i),
	.cmd_scan_len_i(cmd_scan_len_i), .bin_req_o(bin_req_o), .bin_mode_o(bin_mode_o),
	.bin_se_o(bin_se_o), .bin_sub_o(bin_sub_o), .bin_idx_o(bin_idx_o), .bin_vld_i(bin_vld_i),
	.bin_val_i(bin_val_i), .eos_state_o(eos_state_o), .eos_likely_o(eos_likely_o),
	.ctx_reinit_o(ctx_reinit_o), .res_vld_o(res_vld_o), .res_rdy_i(res_rdy_i),
	.res_tag_o(res_tag_o), .res_val_o(res_val_o));

/* File: dv/tb.sv */
// self-checking bench for the bin-to-value block
// assumes the engine model and checker files compile before it
`timescale 1ns/10ps
module tb;
	reg         clk_i = 1'b0, sys_rst_i = 1'b1, cmd_vld_i = 1'b0, cmd_blk_coded_i = 1'b0;
	reg         res_rdy_i = 1'b1;
	reg  [3:0]  cmd_op_i = 4'h0, cmd_mpm_i = 4'h3;
	reg  [4:0]  cmd_scan_len_i = 5'h01;
	wire        cmd_rdy_o, bin_req_o, bin_vld_i, bin_val_i, eos_likely_o, ctx_reinit_o;
	wire        res_vld_o;
	wire [1:0]  bin_mode_o, bin_sub_o;
	wire [3:0]  bin_se_o, res_tag_o;
	wire [4:0]  bin_idx_o;
	wire [5:0]  eos_state_o;
	wire [15:0] res_val_o;
	int         err_count = 0, checks = 0, reinit_n = 0;
	logic [3:0]  rq_t[$]; // results seen, tags
	logic [15:0] rq_v[$]; // results seen, values

	always #5 clk_i = ~clk_i;

	syntax_element_debinarizer uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.cmd_vld_i(cmd_vld_i), .cmd_rdy_o(cmd_rdy_o), .cmd_op_i(cmd_op_i),
		.cmd_mpm_i(cmd_mpm_i), .cmd_blk_coded_i(cmd_blk_coded_i),
		.cmd_scan_len_i(cmd_scan_len_i), .bin_req_o(bin_req_o), .bin_mode_o(bin_mode_o),
		.bin_se_o(bin_se_o), .bin_sub_o(bin_sub_o), .bin_idx_o(bin_idx_o),
		.bin_vld_i(bin_vld_i), .bin_val_i(bin_val_i), .eos_state_o(eos_state_o),
		.eos_likely_o(eos_likely_o), .ctx_reinit_o(ctx_reinit_o), .res_vld_o(res_vld_o),
		.res_rdy_i(res_rdy_i), .res_tag_o(res_tag_o), .res_val_o(res_val_o));
	bin_engine_model eng (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bin_req_i(bin_req_o),
		.bin_mode_i(bin_mode_o), .bin_vld_o(bin_vld_i), .bin_val_o(bin_val_i));

	// collect every accepted result word and count refresh pulses
	always @(posedge clk_i) begin
		if (res_vld_o === 1'b1 && res_rdy_i === 1'b1) begin
			rq_t.push_back(res_tag_o);
			rq_v.push_back(res_val_o);
		end
		if (ctx_reinit_o === 1'b1) reinit_n++;
	end

	task final_report;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// a bounded wait ran out: count it and stop
	task tmo(input string nm);
		chk(nm, 16'h0001, 16'h0000);
		final_report;
	endtask

	// queue n bins, first bin in bit 0
	task load(input int n, input logic [31:0] b);
		for (int i = 0; i < n; i++) eng.push(b[i]);
	endtask

	// offer one command at the falling edge and hold it until taken
	task send(input logic [3:0] op, input logic [4:0] len, input logic cod);
		int i;
		@(negedge clk_i);
		cmd_op_i = op;
		cmd_scan_len_i = len;
		cmd_blk_coded_i = cod;
		cmd_vld_i = 1'b1;
		for (i = 0; i < 100 && cmd_rdy_o !== 1'b1; i++) @(negedge clk_i);
		if (i == 100) tmo("cmd_taken");
		@(negedge clk_i);
		cmd_vld_i = 1'b0;
	endtask

	// take the next result word, compare its tag, and compare its value only when cv is set
	task res(input logic [3:0] t, input logic [15:0] v, input bit cv);
		int i;
		for (i = 0; i < 300 && rq_t.size() == 0; i++) @(negedge clk_i);
		if (rq_t.size() == 0) tmo("result");
		chk("res_tag", {12'h000, t}, {12'h000, rq_t.pop_front()});
		if (cv) chk("res_val", v, rq_v.pop_front());
		else void'(rq_v.pop_front());
	endtask

	// no bins left over and none requested beyond those given
	task idle;
		chk("bins_left", 16'h0000, eng.q.size());
		chk("starved", 16'h0000, eng.starved);
	endtask

	task s_simple;
		logic [15:0] e;
		load(6, 6'h3D); send(4'h0, 5'h01, 1'b0); res(4'h0, 16'h002D, 1);
		for (int k = 0; k < 5; k++) begin
			e = k[0] ? (k + 1) / 2 : -(k / 2);
			load(k + 1, (1 << k) - 1); send(4'h1, 5'h01, 1'b0); res(4'h1, e, 1);
		end
		load(1, 1'h0); send(4'h2, 5'h01, 1'b0); res(4'h2, 16'h0013, 1);
		load(8, 8'hFF); send(4'h2, 5'h01, 1'b0); res(4'h2, 16'h0008, 1);
		load(3, 3'h3); send(4'h2, 5'h01, 1'b0); res(4'h2, 16'h0001, 1);
		load(3, 3'h7); send(4'h3, 5'h01, 1'b0); res(4'h3, 16'h0003, 1);
		load(2, 2'h1); send(4'h3, 5'h01, 1'b0); res(4'h3, 16'h0001, 1);
		load(6, 6'h1F); send(4'h4, 5'h01, 1'b0); res(4'h4, 16'h0005, 1);
		idle;
	endtask

	task s_mvd;
		int b0;
		b0 = eng.byp_n;
		eng.lag = 2;
		load(17, 17'h155FF); send(4'h5, 5'h01, 1'b0);
		res(4'h5, 16'h000E, 1); res(4'h9, 16'hFFFF, 1);
		load(5, 5'h16); send(4'h5, 5'h01, 1'b0);
		res(4'h5, 16'h0000, 1); res(4'h9, 16'hFFFE, 1);
		chk("mvd_bypass", 16'h0007, eng.byp_n - b0);
		eng.lag = 0;
		idle;
	endtask

	task s_coef;
		int b0;
		b0 = eng.byp_n;
		load(11, 11'h1B3); send(4'h6, 5'h04, 1'b1); res(4'h6, 16'hFFFF, 1);
		res(4'h6, 16'h0002, 1); res(4'hA, 16'h0000, 0);
		load(1, 1'h0); send(4'h6, 5'h04, 1'b1); res(4'hA, 16'h0000, 0);
		send(4'h6, 5'h04, 1'b0); res(4'hA, 16'h0000, 0);
		load(17, 17'h07FFF); send(4'h6, 5'h01, 1'b1); res(4'h6, 16'h000F, 1);
		res(4'hA, 16'h0000, 0);
		chk("coef_bypass", 16'h0004, eng.byp_n - b0);
		idle;
	endtask

	task s_flags;
		int r0, e0;
		r0 = reinit_n;
		e0 = eng.eos_n;
		load(1, 1'h1); send(4'h7, 5'h01, 1'b0); res(4'h7, 16'h0000, 1);
		load(1, 1'h0); send(4'h7, 5'h01, 1'b0); res(4'h7, 16'h0001, 1);
		load(1, 1'h0); send(4'h8, 5'h01, 1'b0); res(4'h8, 16'h0000, 1);
		chk("reinit_hold", r0, reinit_n);
		chk("eos_state", 16'h003F, eos_state_o);
		load(1, 1'h1); send(4'h8, 5'h01, 1'b0); res(4'h8, 16'h0001, 1);
		chk("reinit_pulse", r0 + 1, reinit_n);
		chk("eos_bins", 16'h0002, eng.eos_n - e0);
		idle;
	endtask

	// fill the result buffer with the sink stalled, then drain it
	task s_fill;
		res_rdy_i = 1'b0;
		repeat (17) begin
			load(1, 1'h1);
			send(4'h7, 5'h01, 1'b0);
		end
		repeat (10) @(negedge clk_i);
		chk("cmd_rdy_full", 16'h0000, cmd_rdy_o);
		chk("res_vld_full", 16'h0001, res_vld_o);
		res_rdy_i = 1'b1;
		repeat (17) res(4'h7, 16'h0000, 1);
		idle;
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		sys_rst_i = 1'b0;
		s_simple;
		s_mvd;
		s_coef;
		s_flags;
		s_fill;
		final_report;
	end
endmodule
